/* File: rtl/fbm_host.sv */
`timescale 1ns/100ps
// How it works
// - Data is sampled only with chip select and output gate both low.
// - After reset release, no data sampled before 500 ns elapse.
// - Address bit 9 at high voltage enters identifier readout.
// - Host holds address bit 1 low to read maker or part code.
// - Command write: write strobe low, chip select low, output gate high.
// - Protect: bit 9 and gate high voltage, select low, one strobe pulse.
module fbm_host (
	// Clock and reset
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_i,
	// Host request
	input  wire logic                       req_valid_i,
	output logic                            req_ready_o,
	input  wire logic [2:0]                 req_op_i,
	input  wire logic [fbm_pkg::ADDR_W-1:0] req_addr_i,
	input  wire logic [fbm_pkg::DATA_W-1:0] req_data_i,
	// Host answer
	output logic                            rsp_valid_o,
	output logic [fbm_pkg::DATA_W-1:0]      rsp_data_o,
	output logic                            rsp_parity_ok_o,
	output logic                            rsp_protected_o,
	// Standby and unprotect controls
	input  wire logic                       standby_i,
	input  wire logic                       unprotect_i,
	// Flash pins
	output logic [fbm_pkg::ADDR_W-1:0]      flash_addr_o,
	input  wire logic [fbm_pkg::DATA_W-1:0] flash_data_i,
	output logic [fbm_pkg::DATA_W-1:0]      flash_data_o,
	output logic                            flash_data_oe_o,
	output logic                            flash_cs_n_o,
	output logic                            flash_oe_n_o,
	output logic                            flash_we_n_o,
	output logic                            flash_reset_n_o,
	output logic                            high_voltage_select_addr_o,
	output logic                            oe_high_voltage_o,
	output logic                            reset_high_voltage_o
);

	typedef enum logic [2:0] {
		FBM_IDLE,
		FBM_SETUP,
		FBM_STROBE,
		FBM_HOLD,
		FBM_WAKE
	} fbm_state_t;

	fbm_state_t                  state_q;
	fbm_pkg::fbm_op_t            op_q;
	logic [fbm_pkg::DATA_W-1:0]  sync1_q;
	logic [fbm_pkg::DATA_W-1:0]  sync2_q;
	logic                        tmr_load;
	logic [fbm_pkg::CNT_W-1:0]   tmr_value;
	logic                        tmr_done;
	logic                        is_read;
	logic                        accept;

	// Odd parity over a byte
	function automatic logic odd_parity(input logic [fbm_pkg::DATA_W-1:0] b);
		odd_parity = ^b;
	endfunction : odd_parity

	// Cycle count as counter width
	function automatic logic [fbm_pkg::CNT_W-1:0] cyc(input int n);
		cyc = fbm_pkg::CNT_W'(n);
	endfunction : cyc

	fbm_timer u_timer (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.load_i     (tmr_load),
		.value_i    (tmr_value),
		.done_o     (tmr_done)
	);

	assign is_read = (op_q != fbm_pkg::FBM_OP_WRITE) && (op_q != fbm_pkg::FBM_OP_PROT_PROG);
	// Requests wait during standby so reads never see a sleeping device
	assign accept      = (state_q == FBM_IDLE) && req_valid_i && !standby_i;
	assign req_ready_o = (state_q == FBM_IDLE) && !standby_i;

	// Data pins pass two flops; access time covers the extra latency
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= flash_data_i;
			sync2_q <= sync1_q;
		end
	end

	// Sequencer state
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= FBM_WAKE;
		end else begin
			unique case (state_q)
				FBM_IDLE:   if (standby_i) state_q <= FBM_WAKE;
				            else if (accept) state_q <= FBM_SETUP;
				FBM_SETUP:  if (tmr_done) state_q <= FBM_STROBE;
				FBM_STROBE: if (tmr_done) state_q <= FBM_HOLD;
				FBM_HOLD:   if (tmr_done) state_q <= FBM_IDLE;
				FBM_WAKE:   if (!standby_i && flash_reset_n_o && tmr_done) state_q <= FBM_IDLE;
			endcase
		end
	end

	// Phase timing
	always_comb begin
		tmr_load  = 1'b0;
		tmr_value = '0;
		unique case (state_q)
			FBM_IDLE: begin
				tmr_load  = accept || standby_i;
				tmr_value = standby_i ? cyc(fbm_pkg::WAKE_CYC) : cyc(fbm_pkg::SETUP_CYC);
			end
			FBM_SETUP: begin
				tmr_load  = tmr_done;
				tmr_value = (op_q == fbm_pkg::FBM_OP_PROT_PROG) ? cyc(fbm_pkg::PROT_PULSE_CYC) :
				            is_read ? cyc(fbm_pkg::ACCESS_CYC + 2) : cyc(fbm_pkg::STROBE_CYC);
			end
			FBM_STROBE: begin
				tmr_load  = tmr_done;
				tmr_value = cyc(fbm_pkg::SETUP_CYC);
			end
			FBM_HOLD: begin
			end
			FBM_WAKE: begin
				tmr_load  = standby_i || !flash_reset_n_o; // Restart wake time while reset pin low
				tmr_value = cyc(fbm_pkg::WAKE_CYC);
			end
		endcase
	end

	// Request capture; address stays constant through the whole cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_q         <= fbm_pkg::FBM_OP_READ;
			flash_addr_o <= '0;
			flash_data_o <= '0;
		end else if (accept) begin
			op_q         <= fbm_pkg::fbm_op_t'(req_op_i);
			flash_addr_o <= req_addr_i;
			flash_data_o <= req_data_i;
			unique case (fbm_pkg::fbm_op_t'(req_op_i))
				fbm_pkg::FBM_OP_ID_READ: begin
					flash_addr_o[fbm_pkg::ID_QUAL_BIT]   <= 1'b0;
					flash_addr_o[fbm_pkg::ID_REGION_BIT] <= 1'b0;
				end
				fbm_pkg::FBM_OP_PROT_VERIFY: begin
					flash_addr_o[fbm_pkg::ID_QUAL_BIT]   <= 1'b0;
					flash_addr_o[1:0]                    <= fbm_pkg::ID_OFS_PROT;
				end
				default: begin
				end
			endcase
		end
	end

	// Control pins; command writes keep output gate high, select falls before the strobe and rises after it
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flash_cs_n_o    <= 1'b1;
			flash_oe_n_o    <= 1'b1;
			flash_we_n_o    <= 1'b1;
			flash_data_oe_o <= 1'b0;
			high_voltage_select_addr_o <= 1'b0;
			oe_high_voltage_o <= 1'b0;
		end else begin
			flash_cs_n_o <= !(state_q == FBM_SETUP || state_q == FBM_STROBE);
			flash_oe_n_o <= !(state_q == FBM_STROBE && is_read);
			flash_we_n_o <= !(state_q == FBM_STROBE && !is_read &&
			                  tmr_load == 1'b0);
			// Drive data on every write strobe cycle, never with output gate low
			flash_data_oe_o <= (state_q == FBM_SETUP || state_q == FBM_STROBE) &&
			                   !is_read;
			high_voltage_select_addr_o <= (state_q != FBM_IDLE && state_q != FBM_WAKE) &&
			                   (op_q == fbm_pkg::FBM_OP_ID_READ ||
			                    op_q == fbm_pkg::FBM_OP_PROT_PROG ||
			                    op_q == fbm_pkg::FBM_OP_PROT_VERIFY);
			oe_high_voltage_o <= (state_q != FBM_IDLE && state_q != FBM_WAKE) &&
			                     op_q == fbm_pkg::FBM_OP_PROT_PROG;
		end
	end

	// Reset pin and temporary unprotect level
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flash_reset_n_o      <= 1'b0;
			reset_high_voltage_o <= 1'b0;
		end else begin
			// Standby waits for the sequencer so a strobe is never cut by the reset pin
			flash_reset_n_o      <= !(standby_i &&
			                          (state_q == FBM_IDLE || state_q == FBM_WAKE));
			reset_high_voltage_o <= unprotect_i && !standby_i;
		end
	end

	// Answer capture at the end of the read strobe
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rsp_valid_o     <= 1'b0;
			rsp_data_o      <= '0;
			rsp_parity_ok_o <= 1'b0;
			rsp_protected_o <= 1'b0;
		end else begin
			rsp_valid_o <= 1'b0;
			if (state_q == FBM_STROBE && tmr_done && is_read) begin
				rsp_valid_o     <= 1'b1;
				rsp_data_o      <= sync2_q;
				rsp_parity_ok_o <= odd_parity(sync2_q);
				rsp_protected_o <= sync2_q[0];
			end
		end
	end

endmodule : fbm_host

/* File: rtl/fbm_pkg.sv */
package fbm_pkg;

	// Flash side widths
	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;

	// Address bit positions used by the identifier and protection modes
	localparam int HV_SEL_BIT    = 9;
	localparam int ID_BYTE_BIT   = 0;
	localparam int ID_REGION_BIT = 1;
	localparam int ID_QUAL_BIT   = 6;
	localparam int SGA_LO_BIT    = 18;
	localparam int SGA_W         = 3;
	localparam int PARITY_BIT    = 7;

	// Identifier low address offsets
	localparam logic [1:0] ID_OFS_MAKER = 2'h0;
	localparam logic [1:0] ID_OFS_PART  = 2'h1;
	localparam logic [1:0] ID_OFS_PROT  = 2'h2;

	// Clock and timing
	localparam int CLK_PERIOD_NS  = 100;
	localparam int WAKE_NS        = 500;
	localparam int WAKE_CYC       = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_NS      = 200;
	localparam int ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_NS      = 200;
	localparam int STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROT_PULSE_NS  = 1000;
	localparam int PROT_PULSE_CYC = (PROT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC      = 1;
	localparam int CNT_W          = 8;

	// Host request kinds
	typedef enum logic [2:0] {
		FBM_OP_READ,
		FBM_OP_WRITE,
		FBM_OP_ID_READ,
		FBM_OP_PROT_PROG,
		FBM_OP_PROT_VERIFY
	} fbm_op_t;

endpackage : fbm_pkg

/* File: rtl/fbm_timer.sv */
`timescale 1ns/100ps
// Loadable down counter; done is high while the count stands at zero
module fbm_timer (
	// Clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_i,
	// Control
	input  wire logic                     load_i,
	input  wire logic [fbm_pkg::CNT_W-1:0] value_i,
	// Status
	output logic                          done_o
);

	logic [fbm_pkg::CNT_W-1:0] cnt_q;

	// Count down to zero and hold
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (load_i) begin
			cnt_q <= value_i;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// Done looks at the count only; a load term here would loop back through the sequencer
	assign done_o = (cnt_q == '0);

endmodule : fbm_timer

/* File: dv/fbm_host_chk.sv */
`timescale 1ns/100ps
module fbm_host_chk (
	// Clock and reset
	input wire logic                       core_clk_i,
	input wire logic                       rst_i,
	// Flash pins
	input wire logic [fbm_pkg::ADDR_W-1:0] flash_addr_o,
	input wire logic                       flash_data_oe_o,
	input wire logic                       flash_cs_n_o,
	input wire logic                       flash_oe_n_o,
	input wire logic                       flash_we_n_o,
	input wire logic                       flash_reset_n_o,
	input wire logic                       high_voltage_select_addr_o,
	input wire logic                       oe_high_voltage_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Protect pulse: select, high voltages and group held for the first 8 cycles of the strobe
	sequence s_prot_hold;
		(!flash_we_n_o && !flash_cs_n_o && oe_high_voltage_o && high_voltage_select_addr_o
			&& $stable(flash_addr_o[20:18]))[*8];
	endsequence
	// Wake gap: gate stays closed for 500 ns
	sequence s_wake;
		flash_oe_n_o[*5];
	endsequence
	AST_READ_SEL: assert property (!flash_oe_n_o |-> !flash_cs_n_o && !flash_data_oe_o)
		else $error("gate open without select or with host drive");
	AST_WRITE_GATE: assert property (!flash_we_n_o |-> !flash_cs_n_o && flash_oe_n_o)
		else $error("write strobe without select or with gate open");
	AST_WRITE_DRIVE: assert property (!flash_we_n_o |-> flash_data_oe_o)
		else $error("write strobe without host data drive");
	AST_WE_ADDR: assert property (!flash_we_n_o && $past(!flash_we_n_o) |-> $stable(flash_addr_o))
		else $error("address moved during write strobe");
	AST_WAKE: assert property ($rose(flash_reset_n_o) |-> s_wake)
		else $error("read gate opened inside wake time");
	AST_STBY_QUIET: assert property (!flash_reset_n_o |-> flash_oe_n_o && flash_we_n_o)
		else $error("strobe active in reset standby");
	AST_ID_ADDR: assert property (high_voltage_select_addr_o && !flash_oe_n_o && !flash_addr_o[1]
		|-> !flash_addr_o[6])
		else $error("identifier read with qualifier bit high");
	AST_PROT_PULSE: assert property ($fell(flash_we_n_o) && oe_high_voltage_o |-> s_prot_hold)
		else $error("protect pulse conditions broken");
endmodule : fbm_host_chk

bind fbm_host fbm_host_chk i_fbm_host_chk (.core_clk_i, .rst_i, .flash_addr_o, .flash_data_oe_o,
	.flash_cs_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o,
	.high_voltage_select_addr_o, .oe_high_voltage_o);

/* File: dv/fbm_flash_model.sv */
`timescale 1ns/100ps
module fbm_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h01, // Arbitrary value, odd parity
	parameter logic [7:0] PART_CODE  = 8'h07  // Arbitrary value, odd parity
) (
	// Flash pins from the host
	input wire logic [20:0] flash_addr_o,
	input wire logic [7:0]  flash_data_o,
	input wire logic        flash_cs_n_o,
	input wire logic        flash_oe_n_o,
	input wire logic        flash_we_n_o,
	input wire logic        flash_reset_n_o,
	input wire logic        high_voltage_select_addr_o,
	input wire logic        oe_high_voltage_o,
	input wire logic        reset_high_voltage_o,
	// Data back to the host
	output logic [7:0]      flash_data_i
);
	logic [7:0]  mem [32];
	logic [7:0]  prot;
	logic [20:0] lat_a;
	logic [7:0]  rd_v;
	logic [7:0]  last_v;
	logic        drv;
	realtime     wake_t;
	// Erased array, all groups open
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		prot = 8'h00;
		last_v = 8'h00;
		wake_t = 0;
	end
	// Wake time counted from reset release
	always @(posedge flash_reset_n_o) wake_t = $realtime + 500.0;
	// Address taken at the later falling edge
	always @(negedge (flash_cs_n_o | flash_we_n_o)) lat_a = flash_addr_o;
	// Data taken at the earlier rising edge; guard skips reset glitches
	always @(posedge (flash_cs_n_o | flash_we_n_o)) begin
		if (flash_reset_n_o === 1'b1 && (flash_oe_n_o || oe_high_voltage_o)) begin
			if (oe_high_voltage_o && high_voltage_select_addr_o)
				prot[lat_a[20:18]] = 1'b1;
			else if (!prot[lat_a[20:18]] || reset_high_voltage_o)
				mem[{lat_a[20:18], lat_a[1:0]}] = flash_data_o;
		end
	end
	// Read path; released lines show the inverse of the last byte
	always @* begin
		if (high_voltage_select_addr_o)
			rd_v = flash_addr_o[1] ? {7'h00, prot[flash_addr_o[20:18]]}
				: (flash_addr_o[0] ? PART_CODE : MAKER_CODE);
		else
			rd_v = mem[{flash_addr_o[20:18], flash_addr_o[1:0]}];
		drv = !flash_cs_n_o && !flash_oe_n_o && flash_reset_n_o && $realtime >= wake_t;
		if (drv) last_v = rd_v;
		flash_data_i = drv ? rd_v : ~last_v;
	end
endmodule : fbm_flash_model

/* File: dv/flash_bus_modes_and_group_protect_bench.sv */
`timescale 1ns/100ps
module flash_bus_modes_and_group_protect_bench;
	typedef struct packed {logic [2:0] op; logic [20:0] a; logic [7:0] d; logic u; logic [7:0] e;} fbm_row_t;
	logic core_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, standby_i = 1'b0, unprotect_i = 1'b0;
	logic [2:0] req_op_i = 3'h0;
	logic [20:0] req_addr_i = 21'h0;
	logic [7:0] req_data_i = 8'h00, got, flash_data_i, flash_data_o, rsp_data_o;
	logic req_ready_o, rsp_valid_o, rsp_parity_ok_o, rsp_protected_o, flash_data_oe_o, flash_cs_n_o;
	logic flash_oe_n_o, flash_we_n_o, flash_reset_n_o, high_voltage_select_addr_o, oe_high_voltage_o;
	logic reset_high_voltage_o;
	logic [20:0] flash_addr_o;
	int n_fail = 0, n_checks = 0, i;
	// Ordinary cases: op, address, data, unprotect, expected byte
	fbm_row_t rows [15] = '{'{0, 21'h3, 0, 0, 8'hFF}, '{1, 21'h3, 8'h5A, 0, 0}, '{0, 21'h3, 0, 0, 8'h5A},
		'{2, 21'hFFFC, 0, 0, 8'h01}, '{2, 21'hFFFD, 0, 0, 8'h07}, '{4, 21'h140000, 0, 0, 8'h00},
		'{3, 21'h140000, 0, 0, 0}, '{4, 21'h140000, 0, 0, 8'h01}, '{4, 21'h100000, 0, 0, 8'h00},
		'{1, 21'h140001, 8'h11, 0, 0}, '{0, 21'h140001, 0, 0, 8'hFF},
		'{1, 21'h140001, 8'h22, 1, 0}, '{0, 21'h140001, 0, 1, 8'h22},
		'{1, 21'h140002, 8'h33, 0, 0}, '{0, 21'h140002, 0, 0, 8'hFF}};
	fbm_host i_fbm_host (.core_clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_op_i, .req_addr_i,
		.req_data_i, .rsp_valid_o, .rsp_data_o, .rsp_parity_ok_o, .rsp_protected_o, .standby_i,
		.unprotect_i, .flash_addr_o, .flash_data_i, .flash_data_o, .flash_data_oe_o, .flash_cs_n_o,
		.flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o, .high_voltage_select_addr_o,
		.oe_high_voltage_o, .reset_high_voltage_o);
	fbm_flash_model i_fbm_flash_model (.flash_addr_o, .flash_data_o, .flash_cs_n_o, .flash_oe_n_o,
		.flash_we_n_o, .flash_reset_n_o, .high_voltage_select_addr_o, .oe_high_voltage_o,
		.reset_high_voltage_o, .flash_data_i);
	// Clock at 10 MHz
	initial forever #50 core_clk_i = ~core_clk_i;
	// Keep the last answered byte
	always @(posedge core_clk_i) if (rsp_valid_o === 1'b1) got <= rsp_data_o;
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	// Bounded wait at falling edges; a hang ends the run
	task wait_ready;
		for (i = 0; i < 60 && req_ready_o !== 1'b1; i++) @(negedge core_clk_i);
		if (i == 60) begin
			n_fail++;
			close_out;
		end
	endtask : wait_ready
	task req(input fbm_row_t r);
		unprotect_i = r.u;
		wait_ready;
		{req_valid_i, req_op_i, req_addr_i, req_data_i} = {1'b1, r.op, r.a, r.d};
		@(negedge core_clk_i) req_valid_i = 1'b0;
		wait_ready;
	endtask : req
	initial begin
		repeat (12) @(negedge core_clk_i);
		rst_i = 1'b0;
		foreach (rows[k]) begin
			req(rows[k]);
			if (rows[k].op inside {3'h0, 3'h2, 3'h4}) chk(got, rows[k].e);
			if (rows[k].op == 3'h2) chk({7'h00, rsp_parity_ok_o}, 8'h01);
			if (rows[k].op == 3'h4) chk({7'h00, rsp_protected_o}, rows[k].e);
		end
		// Reset standby: pin low, no requests; wake gap after release
		standby_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk({6'h00, req_ready_o, flash_reset_n_o}, 8'h00);
		standby_i = 1'b0;
		wait_ready;
		chk({7'h00, i >= 5}, 8'h01);
		req('{0, 21'h3, 0, 0, 0});
		chk(got, 8'h5A);
		// Mid-run reset parks the pins
		rst_i = 1'b1;
		@(negedge core_clk_i);
		chk({3'h0, flash_cs_n_o, flash_oe_n_o, flash_we_n_o, flash_reset_n_o, flash_data_oe_o}, 8'h1C);
		rst_i = 1'b0;
		req('{2, 21'h1, 0, 0, 0});
		chk(got, 8'h07);
		close_out;
	end
endmodule : flash_bus_modes_and_group_protect_bench
